// ### rtl/tag_editor_pkg.sv
package tag_editor_pkg;

   // Bus register byte offsets
   localparam logic [7:0] OFS_EGRESS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DVID_P0     = 8'h04;
   localparam logic [7:0] OFS_DVID_P1     = 8'h08;
   localparam logic [7:0] OFS_DVID_P2     = 8'h0C;
   localparam logic [7:0] OFS_TOTAL_P0    = 8'h10;
   localparam logic [7:0] OFS_RATE_P0     = 8'h1C;
   localparam logic [7:0] OFS_UNTAG_BASE  = 8'h40;
   localparam logic [7:0] OFS_UNTAG_LAST  = 8'h7C;

   // Sizes
   localparam int NUM_PORTS    = 3;
   localparam int VID_W        = 12;
   localparam int PRIO_W       = 3;
   localparam int TBL_AW       = 4;
   localparam int CNT_W        = 32;
   localparam int CTRL_STRIDE  = 8;

   // Per-port field positions inside egress_tag_control_reg
   localparam int CTL_TYPE_LSB = 0;
   localparam int CTL_INSERT   = 2;
   localparam int CTL_CHG_TAG  = 3;
   localparam int CTL_CHG_VID  = 4;
   localparam int CTL_CHG_PRIO = 5;
   localparam int CTL_SEL_ING  = 6;

   // Default VID and priority register layout
   localparam int DV_VID_LSB   = 0;
   localparam int DV_PRIO_LSB  = 12;

   // Tag control word layout
   localparam int TCI_VID_LSB  = 0;
   localparam int TCI_CFI      = 12;
   localparam int TCI_PRIO_LSB = 13;

   // Reset values and the null VID of a priority tag
   localparam logic [31:0] EGRESS_CTRL_RST = 32'h0000_0000;
   localparam logic [14:0] DVID_RST        = 15'h0001;
   localparam logic [11:0] VID_NONE        = 12'h000;

   // AHB encodings
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
   localparam logic [1:0]  HRESP_OKAY      = 2'h0;

   typedef enum logic [1:0] {
      CLS_UNTAGGED,
      CLS_PRIO,
      CLS_NORMAL,
      CLS_SPECIAL
   } pkt_class_t;

   typedef enum logic [1:0] {
      PT_DUMB,
      PT_ACCESS,
      PT_HYBRID,
      PT_CPU
   } port_type_t;

   typedef enum logic [2:0] {
      ACT_PASS,
      ACT_INSERT,
      ACT_REMOVE,
      ACT_MODIFY,
      ACT_STRIP_SPECIAL,
      ACT_ADD_SPECIAL
   } tag_action_t;

endpackage

// ### rtl/vlan_untag_mem.sv
`timescale 1ns/1ns
module vlan_untag_mem (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Write port
   input  wire logic        wr_en,
   input  wire logic [3:0]  wr_addr,
   input  wire logic [2:0]  wr_data,
   // Read port for the edit path
   input  wire logic [3:0]  rd_a_addr,
   output logic      [2:0]  rd_a_data,
   // Read port for the bus
   input  wire logic [3:0]  rd_b_addr,
   output logic      [2:0]  rd_b_data
);

   logic [2:0] mem [16];

   // No reset on the array; software loads it before use
   always_ff @(posedge hclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_a_data <= 3'h0;
         rd_b_data <= 3'h0;
      end else begin
         rd_a_data <= mem[rd_a_addr];
         rd_b_data <= mem[rd_b_addr];
      end
   end

endmodule

// ### rtl/egress_vlan_tag_editor.sv
// Functional notes
// RULE_01: Each packet is classed untagged, priority, normal or special.
// RULE_02: Each egress port has a type: dumb, access, hybrid or CPU.
// RULE_03: Dumb port passes untagged, priority and normal packets unchanged.
// RULE_04: Dumb, access and hybrid ports strip the CPU special tag.
// RULE_05: Access port passes untagged packets unchanged.
// RULE_06: Access port removes priority or normal tags.
// RULE_07: CPU port sends packets with the special tag.
// RULE_08: Un-tag bits come from entry of packet VID or ingress default.
// RULE_09: Hybrid inserts tag if insert set and default-VID un-tag bit clear.
// RULE_10: Inserted VID and priority come from ingress or egress per select.
// RULE_11: Hybrid priority-tagged: remove if un-tag bit set, else modify.
// RULE_12: Priority tag modify sets VID; priority only with change-priority.
// RULE_13: Hybrid normal-tagged: remove when own-VID un-tag bit set.
// RULE_14: Normal tag kept unchanged when change-tag is clear.
// RULE_15: Normal tag kept when change-VID and change-priority both clear.
// RULE_16: Normal tag modify with change-VID takes VID from selected default.
// RULE_17: Normal tag modify with change-priority takes priority likewise.
// RULE_18: Default VID and priority held per port, software writable.
// RULE_19: Per ingress port total drop count, buffer plus rate drops.
// RULE_20: Per ingress port separate count of rate-limit drops only.
// RULE_21: A rate drop increments both counters of its port.
// RULE_22: Any tag insert, removal or change requests FCS recomputation.
`timescale 1ns/1ns
module egress_vlan_tag_editor (
   // Clock and reset
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   // AHB-Lite slave
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic      [31:0]               hrdata,
   output logic                           hreadyout,
   output logic      [1:0]                hresp,
   // Edit request from the queue side
   input  wire logic                      req_valid,
   input  wire logic [1:0]                req_egress_port,
   input  wire logic [1:0]                req_ingress_port,
   input  wire logic                      req_has_tag,
   input  wire logic                      req_special,
   input  wire logic [15:0]               req_tci,
   input  wire logic [2:0]                req_ingress_prio,
   // Edit decision toward the transmit MAC
   output logic                           edit_valid,
   output tag_editor_pkg::tag_action_t    edit_action,
   output logic      [15:0]               edit_tci,
   output logic                           edit_fcs_regen,
   // Drop events from ingress
   input  wire logic                      drop_valid,
   input  wire logic [1:0]                drop_port,
   input  wire logic                      drop_by_rate
);

   localparam int NP = tag_editor_pkg::NUM_PORTS;
   localparam int CW = tag_editor_pkg::CNT_W;

   // Configuration state
   logic [31:0] egress_tag_control_reg;
   logic [14:0] dvid_prio_r [NP];
   logic [CW-1:0] total_cnt_r [NP];
   logic [CW-1:0] rate_cnt_r [NP];

   // Bus pipeline
   logic        dph_valid_r;
   logic        dph_write_r;
   logic [7:0]  dph_addr_r;
   logic        rd_wait_r;
   logic        aph_take;
   logic        wr_take;
   logic        tbl_wr;
   logic [2:0]  tbl_b_data;

   assign aph_take = hsel && hready && (htrans == tag_editor_pkg::HTRANS_NONSEQ);
   assign wr_take  = dph_valid_r && dph_write_r;
   assign tbl_wr   = wr_take
                     && dph_addr_r >= tag_editor_pkg::OFS_UNTAG_BASE
                     && dph_addr_r <= tag_editor_pkg::OFS_UNTAG_LAST;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_valid_r <= 1'b0;
         dph_write_r <= 1'b0;
         dph_addr_r  <= 8'h00;
      end else if (hready) begin
         dph_valid_r <= aph_take;
         dph_write_r <= hwrite;
         dph_addr_r  <= {haddr[7:2], 2'b00};
      end
   end

   // One wait state on reads so hrdata comes from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait_r <= 1'b0;
         hreadyout <= 1'b1;
      end else begin
         rd_wait_r <= aph_take && !hwrite;
         hreadyout <= !(aph_take && !hwrite);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= tag_editor_pkg::HRESP_OKAY;
      end else begin
         hresp <= tag_editor_pkg::HRESP_OKAY;
      end
   end

   // Read mux; unmapped words read zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (dph_addr_r)
         tag_editor_pkg::OFS_EGRESS_CTRL: rd_mux = egress_tag_control_reg;
         tag_editor_pkg::OFS_DVID_P0:     rd_mux = 32'(dvid_prio_r[0]);
         tag_editor_pkg::OFS_DVID_P1:     rd_mux = 32'(dvid_prio_r[1]);
         tag_editor_pkg::OFS_DVID_P2:     rd_mux = 32'(dvid_prio_r[2]);
         8'h10:                           rd_mux = total_cnt_r[0];
         8'h14:                           rd_mux = total_cnt_r[1];
         8'h18:                           rd_mux = total_cnt_r[2];
         8'h1C:                           rd_mux = rate_cnt_r[0];
         8'h20:                           rd_mux = rate_cnt_r[1];
         8'h24:                           rd_mux = rate_cnt_r[2];
         default: begin
            if (dph_addr_r >= tag_editor_pkg::OFS_UNTAG_BASE
                && dph_addr_r <= tag_editor_pkg::OFS_UNTAG_LAST) begin
               rd_mux = {29'h0000_0000, tbl_b_data};
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_wait_r) begin
         hrdata <= rd_mux;
      end
   end

   // Egress control register; hsize ignored, whole words only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         egress_tag_control_reg <= tag_editor_pkg::EGRESS_CTRL_RST;
      end else if (wr_take
                   && dph_addr_r == tag_editor_pkg::OFS_EGRESS_CTRL) begin
         egress_tag_control_reg <= hwdata; // see RULE_02
      end
   end

   // Per-port defaults and drop counters
   genvar gp;
   generate
      for (gp = 0; gp < NP; gp++) begin : g_port
         localparam logic [7:0] DV_OFS =
            8'(tag_editor_pkg::OFS_DVID_P0 + 4 * gp);

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               dvid_prio_r[gp] <= tag_editor_pkg::DVID_RST;
            end else if (wr_take && dph_addr_r == DV_OFS) begin
               dvid_prio_r[gp] <= hwdata[14:0]; // see RULE_18
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               total_cnt_r[gp] <= '0;
            end else if (drop_valid && drop_port == 2'(gp)) begin
               total_cnt_r[gp] <= total_cnt_r[gp] + 1'b1; // see RULE_19
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               rate_cnt_r[gp] <= '0;
            end else if (drop_valid && drop_by_rate
                         && drop_port == 2'(gp)) begin
               rate_cnt_r[gp] <= rate_cnt_r[gp] + 1'b1; // see RULE_20, RULE_21
            end
         end
      end
   endgenerate

   // Stage 0: classify and pick the table entry
   tag_editor_pkg::pkt_class_t cls_nxt;
   logic [3:0]  tbl_a_addr;
   logic [11:0] ing_dvid;

   assign ing_dvid = dvid_prio_r[req_ingress_port][11:0];

   always_comb begin
      if (req_special) begin
         cls_nxt = tag_editor_pkg::CLS_SPECIAL; // see RULE_01
      end else if (!req_has_tag) begin
         cls_nxt = tag_editor_pkg::CLS_UNTAGGED;
      end else if (req_tci[11:0] == tag_editor_pkg::VID_NONE) begin
         cls_nxt = tag_editor_pkg::CLS_PRIO;
      end else begin
         cls_nxt = tag_editor_pkg::CLS_NORMAL;
      end
   end

   // Own VID only for normal tags, else the ingress default
   assign tbl_a_addr = (cls_nxt == tag_editor_pkg::CLS_NORMAL)
                       ? req_tci[3:0] : ing_dvid[3:0]; // see RULE_08

   logic [2:0] untag_bits;

   vlan_untag_mem u_untag (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .wr_en     (tbl_wr),
      .wr_addr   (dph_addr_r[5:2]),
      .wr_data   (hwdata[2:0]),
      .rd_a_addr (tbl_a_addr),
      .rd_a_data (untag_bits),
      .rd_b_addr (haddr[5:2]),
      .rd_b_data (tbl_b_data)
   );

   // Stage 1: hold the request while the table answers
   logic                       s1_valid_r;
   tag_editor_pkg::pkt_class_t s1_cls_r;
   logic [1:0]                 s1_eg_r;
   logic [11:0]                s1_ing_vid_r;
   logic [15:0]                s1_tci_r;
   logic [2:0]                 s1_ing_prio_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_valid_r    <= 1'b0;
         s1_cls_r      <= tag_editor_pkg::CLS_UNTAGGED;
         s1_eg_r       <= 2'h0;
         s1_ing_vid_r  <= 12'h000;
         s1_tci_r      <= 16'h0000;
         s1_ing_prio_r <= 3'h0;
      end else begin
         s1_valid_r <= req_valid;
         if (req_valid) begin
            s1_cls_r      <= cls_nxt;
            s1_eg_r       <= req_egress_port;
            s1_ing_vid_r  <= ing_dvid;
            s1_tci_r      <= req_tci;
            s1_ing_prio_r <= req_ingress_prio;
         end
      end
   end

   // Stage 1 decision
   logic [7:0]  ctl;
   tag_editor_pkg::port_type_t ptype;
   logic        untag;
   logic [11:0] sel_vid;
   logic [2:0]  sel_prio;
   logic [14:0] eg_dv;
   tag_editor_pkg::tag_action_t act_nxt;
   logic [15:0] tci_nxt;

   assign ctl   = egress_tag_control_reg[s1_eg_r * tag_editor_pkg::CTRL_STRIDE
                                         +: tag_editor_pkg::CTRL_STRIDE];
   assign ptype = tag_editor_pkg::port_type_t'(
                     ctl[tag_editor_pkg::CTL_TYPE_LSB +: 2]);
   assign untag = untag_bits[s1_eg_r];
   assign eg_dv = dvid_prio_r[s1_eg_r];

   // Select bit picks ingress or egress source
   assign sel_vid  = ctl[tag_editor_pkg::CTL_SEL_ING]
                     ? s1_ing_vid_r : eg_dv[11:0]; // see RULE_10
   assign sel_prio = ctl[tag_editor_pkg::CTL_SEL_ING]
                     ? s1_ing_prio_r : eg_dv[14:12];

   always_comb begin
      act_nxt = tag_editor_pkg::ACT_PASS;
      tci_nxt = s1_tci_r;
      if (ptype == tag_editor_pkg::PT_CPU) begin
         act_nxt = tag_editor_pkg::ACT_ADD_SPECIAL; // see RULE_07
      end else if (s1_cls_r == tag_editor_pkg::CLS_SPECIAL) begin
         act_nxt = tag_editor_pkg::ACT_STRIP_SPECIAL; // see RULE_04
      end else begin
         unique case (ptype)
            tag_editor_pkg::PT_DUMB: begin
               act_nxt = tag_editor_pkg::ACT_PASS; // see RULE_03
            end
            tag_editor_pkg::PT_ACCESS: begin
               if (s1_cls_r == tag_editor_pkg::CLS_UNTAGGED) begin
                  act_nxt = tag_editor_pkg::ACT_PASS; // see RULE_05
               end else begin
                  act_nxt = tag_editor_pkg::ACT_REMOVE; // see RULE_06
               end
            end
            tag_editor_pkg::PT_HYBRID: begin
               unique case (s1_cls_r)
                  tag_editor_pkg::CLS_UNTAGGED: begin
                     if (ctl[tag_editor_pkg::CTL_INSERT] && !untag) begin
                        act_nxt = tag_editor_pkg::ACT_INSERT; // see RULE_09
                        tci_nxt = {sel_prio, 1'b0, sel_vid}; // see RULE_10
                     end
                  end
                  tag_editor_pkg::CLS_PRIO: begin
                     if (untag) begin
                        act_nxt = tag_editor_pkg::ACT_REMOVE; // see RULE_11
                     end else begin
                        act_nxt = tag_editor_pkg::ACT_MODIFY;
                        tci_nxt[11:0] = sel_vid; // see RULE_12
                        if (ctl[tag_editor_pkg::CTL_CHG_PRIO]) begin
                           tci_nxt[15:13] = sel_prio;
                        end
                     end
                  end
                  default: begin
                     if (untag) begin
                        act_nxt = tag_editor_pkg::ACT_REMOVE; // see RULE_13
                     end else if (!ctl[tag_editor_pkg::CTL_CHG_TAG]) begin
                        act_nxt = tag_editor_pkg::ACT_PASS; // see RULE_14
                     end else if (!ctl[tag_editor_pkg::CTL_CHG_VID]
                                  && !ctl[tag_editor_pkg::CTL_CHG_PRIO]) begin
                        act_nxt = tag_editor_pkg::ACT_PASS; // see RULE_15
                     end else begin
                        act_nxt = tag_editor_pkg::ACT_MODIFY;
                        if (ctl[tag_editor_pkg::CTL_CHG_VID]) begin
                           tci_nxt[11:0] = sel_vid; // see RULE_16
                        end
                        if (ctl[tag_editor_pkg::CTL_CHG_PRIO]) begin
                           tci_nxt[15:13] = sel_prio; // see RULE_17
                        end
                     end
                  end
               endcase
            end
            default: begin
               act_nxt = tag_editor_pkg::ACT_ADD_SPECIAL;
            end
         endcase
      end
   end

   // Stage 2: registered decision
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         edit_valid     <= 1'b0;
         edit_action    <= tag_editor_pkg::ACT_PASS;
         edit_tci       <= 16'h0000;
         edit_fcs_regen <= 1'b0;
      end else begin
         edit_valid <= s1_valid_r;
         if (s1_valid_r) begin
            edit_action    <= act_nxt;
            edit_tci       <= tci_nxt;
            edit_fcs_regen <= act_nxt
                              != tag_editor_pkg::ACT_PASS; // see RULE_22
         end
      end
   end

endmodule

// ### verification/tag_edit_monitor.sv
`timescale 1ns/1ns
module tag_edit_monitor (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   // Edit path
   input wire logic        req_valid,
   input wire logic        req_has_tag,
   input wire logic        req_special,
   input wire logic [15:0] req_tci,
   input wire logic        edit_valid,
   input wire tag_editor_pkg::tag_action_t edit_action,
   input wire logic [15:0] edit_tci,
   input wire logic        edit_fcs_regen
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_addr;
      hsel && hready && htrans == tag_editor_pkg::HTRANS_NONSEQ;
   endsequence
   sequence s_rd_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   // Fixed two-cycle answer, so stalls upstream never reorder results
   a_edit_latency: assert property (
      edit_valid == $past(req_valid, 2))
      else $error("edit answer not two cycles after request");
   a_fcs_regen: assert property (
      edit_valid |-> edit_fcs_regen ==
      (edit_action != tag_editor_pkg::ACT_PASS))
      else $error("fcs regen does not follow the action");
   a_special_only: assert property (
      req_valid && req_special |-> ##2 edit_action inside
      {tag_editor_pkg::ACT_STRIP_SPECIAL, tag_editor_pkg::ACT_ADD_SPECIAL})
      else $error("special packet got a plain tag action");
   a_untag_no_edit: assert property (
      req_valid && !req_has_tag && !req_special |-> ##2 edit_action inside
      {tag_editor_pkg::ACT_PASS, tag_editor_pkg::ACT_INSERT,
      tag_editor_pkg::ACT_ADD_SPECIAL})
      else $error("untagged packet removed or modified");
   a_tag_no_insert: assert property (
      req_valid && req_has_tag && !req_special |-> ##2 !(edit_action inside
      {tag_editor_pkg::ACT_INSERT, tag_editor_pkg::ACT_STRIP_SPECIAL}))
      else $error("tagged packet got an insert");
   a_tci_kept: assert property (
      edit_valid && !(edit_action inside {tag_editor_pkg::ACT_INSERT,
      tag_editor_pkg::ACT_MODIFY}) |-> edit_tci == $past(req_tci, 2))
      else $error("tag word changed without modify");
   a_hold_result: assert property (
      !edit_valid |-> $stable(edit_action) && $stable(edit_tci))
      else $error("result moved between answers");
   a_read_wait: assert property (
      s_addr ##0 !hwrite |=> s_rd_wait)
      else $error("read wait state wrong");
   a_write_ready: assert property (
      s_addr ##0 hwrite |=> hreadyout)
      else $error("write stalled");
endmodule
bind egress_vlan_tag_editor tag_edit_monitor mon (
   .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
   .req_valid, .req_has_tag, .req_special, .req_tci, .edit_valid,
   .edit_action, .edit_tci, .edit_fcs_regen
);

// ### verification/ingress_model.sv
`timescale 1ns/1ns
module ingress_model (
   // Clock
   input  wire logic   hclk,
   // Edit requests
   output logic        req_valid,
   output logic [1:0]  req_egress_port,
   output logic [1:0]  req_ingress_port,
   output logic        req_has_tag,
   output logic        req_special,
   output logic [15:0] req_tci,
   output logic [2:0]  req_ingress_prio,
   // Drop events
   output logic        drop_valid,
   output logic [1:0]  drop_port,
   output logic        drop_by_rate
);
   initial begin
      {req_valid, drop_valid, drop_port, drop_by_rate} = 5'h00;
      {req_egress_port, req_ingress_port, req_has_tag, req_special} = 6'h00;
      {req_tci, req_ingress_prio} = 19'h0_0000;
   end

   // Caller enters just after an edge; back-to-back calls stay legal
   task automatic send(input logic [1:0] eg, ip, input logic tg, sp,
                       input logic [15:0] tci);
      req_valid <= 1'h1;
      {req_egress_port, req_ingress_port} <= {eg, ip};
      {req_has_tag, req_special} <= {tg, sp};
      req_tci <= tci;
      req_ingress_prio <= 3'h5;
      @(posedge hclk);
   endtask

   task automatic drop(input logic [1:0] p, input logic r);
      {drop_valid, drop_port, drop_by_rate} <= {1'h1, p, r};
      @(posedge hclk);
   endtask

   // Idle fields inverted so a stale value never passes for a request
   task automatic idle;
      {req_valid, drop_valid} <= 2'h0;
      {req_egress_port, req_ingress_port, req_has_tag, req_special}
         <= ~{req_egress_port, req_ingress_port, req_has_tag, req_special};
      {req_tci, req_ingress_prio, drop_port, drop_by_rate}
         <= ~{req_tci, req_ingress_prio, drop_port, drop_by_rate};
   endtask
endmodule

// ### verification/tb_egress_vlan_tag_editor.sv
`timescale 1ns/1ns
module tb_egress_vlan_tag_editor;
   typedef struct {
      logic [7:0]  c;
      logic [1:0]  eg, ip;
      logic        tg, sp;
      logic [15:0] tci;
      logic [2:0]  act;
      logic [15:0] et;
   } row_t;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout;
   logic        req_valid, req_has_tag, req_special, edit_valid;
   logic        edit_fcs_regen, drop_valid, drop_by_rate;
   logic [1:0]  htrans, hresp, req_egress_port, req_ingress_port, drop_port;
   logic [2:0]  hsize, req_ingress_prio;
   logic [15:0] req_tci, edit_tci;
   logic [31:0] haddr, hwdata, hrdata, rd;
   tag_editor_pkg::tag_action_t edit_action;
   int          failures, tests_run, n;
   // Type byte, egress, ingress, tagged, special, tci, action, result tci
   row_t rows [20] = '{
      '{8'h00, 2'h0, 2'h0, 1'h1, 1'h0, 16'h6003, 3'h0, 16'h6003},
      '{8'h00, 2'h0, 2'h0, 1'h0, 1'h1, 16'h1234, 3'h4, 16'h1234},
      '{8'h01, 2'h1, 2'h0, 1'h0, 1'h0, 16'h0000, 3'h0, 16'h0000},
      '{8'h01, 2'h1, 2'h0, 1'h1, 1'h0, 16'h6003, 3'h2, 16'h6003},
      '{8'h01, 2'h1, 2'h0, 1'h1, 1'h0, 16'hA000, 3'h2, 16'hA000},
      '{8'h03, 2'h1, 2'h0, 1'h0, 1'h0, 16'h0000, 3'h5, 16'h0000},
      '{8'h06, 2'h2, 2'h0, 1'h0, 1'h0, 16'h0000, 3'h1, 16'hC00A},
      '{8'h46, 2'h2, 2'h0, 1'h0, 1'h0, 16'h0000, 3'h1, 16'hA005},
      '{8'h06, 2'h2, 2'h1, 1'h0, 1'h0, 16'h0000, 3'h0, 16'h0000},
      '{8'h02, 2'h2, 2'h0, 1'h0, 1'h0, 16'h0000, 3'h0, 16'h0000},
      '{8'h02, 2'h2, 2'h1, 1'h1, 1'h0, 16'h2000, 3'h2, 16'h2000},
      '{8'h02, 2'h2, 2'h0, 1'h1, 1'h0, 16'h2000, 3'h3, 16'h200A},
      '{8'h62, 2'h2, 2'h0, 1'h1, 1'h0, 16'h2000, 3'h3, 16'hA005},
      '{8'h3E, 2'h2, 2'h0, 1'h1, 1'h0, 16'h6003, 3'h2, 16'h6003},
      '{8'h02, 2'h2, 2'h0, 1'h1, 1'h0, 16'h6004, 3'h0, 16'h6004},
      '{8'h0A, 2'h2, 2'h0, 1'h1, 1'h0, 16'h6004, 3'h0, 16'h6004},
      '{8'h1A, 2'h2, 2'h0, 1'h1, 1'h0, 16'h6004, 3'h3, 16'h600A},
      '{8'h2A, 2'h2, 2'h0, 1'h1, 1'h0, 16'h6004, 3'h3, 16'hC004},
      '{8'h7A, 2'h2, 2'h0, 1'h1, 1'h0, 16'h6004, 3'h3, 16'hA005},
      '{8'h02, 2'h2, 2'h0, 1'h0, 1'h1, 16'h1234, 3'h4, 16'h1234}
   };

   assign hready = hreadyout;
   egress_vlan_tag_editor dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .req_valid, .req_egress_port,
      .req_ingress_port, .req_has_tag, .req_special, .req_tci,
      .req_ingress_prio, .edit_valid, .edit_action, .edit_tci,
      .edit_fcs_regen, .drop_valid, .drop_port, .drop_by_rate
   );
   ingress_model ing (
      .hclk, .req_valid, .req_egress_port, .req_ingress_port, .req_has_tag,
      .req_special, .req_tci, .req_ingress_prio, .drop_valid, .drop_port,
      .drop_by_rate
   );

   initial begin
      hclk = 1'h0;
      forever #25 hclk = ~hclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      {hsel, hwrite, haddr} <= {1'h1, w, 24'h00_0000, a};
      htrans <= tag_editor_pkg::HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'h0, a, 32'h0000_0000);
      chk(rd, exp);
      chk(32'(hresp), 32'h0000_0000);
   endtask

   // Bounded wait; a missing answer shows up as edit_valid low
   task automatic wait_edit;
      n = 0;
      while (edit_valid !== 1'h1 && n < 8) begin
         @(posedge hclk);
         n++;
      end
   endtask

   task automatic conclude;
      if (failures == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge hclk);
      failures++;
      conclude();
   end

   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 69'h0;
      hsize = 3'h2;
      failures = 0;
      tests_run = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'h1;
      rdchk(8'h00, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         rdchk(8'h04 + 8'(4 * i), 32'h0000_0001);
         rdchk(8'h10 + 8'(4 * i), 32'h0000_0000);
      end
      bus(1'h1, 8'h04, 32'h0000_2005);
      bus(1'h1, 8'h08, 32'h0000_1007);
      bus(1'h1, 8'h0C, 32'h0000_600A);
      rdchk(8'h0C, 32'h0000_600A);
      bus(1'h1, 8'h4C, 32'h0000_0004);
      bus(1'h1, 8'h50, 32'h0000_0000);
      bus(1'h1, 8'h54, 32'h0000_0000);
      bus(1'h1, 8'h5C, 32'h0000_0004);
      rdchk(8'h5C, 32'h0000_0004);
      foreach (rows[i]) begin
         // Other ports fall back to dumb while one lane is under test
         bus(1'h1, 8'h00, 32'(rows[i].c) << (8 * rows[i].eg));
         ing.send(rows[i].eg, rows[i].ip, rows[i].tg, rows[i].sp,
                  rows[i].tci);
         ing.idle();
         wait_edit();
         chk(32'({edit_valid, edit_fcs_regen, edit_action, edit_tci}),
             {11'h000, 1'h1, rows[i].act != 3'h0, rows[i].act,
              rows[i].et});
      end
      bus(1'h1, 8'h00, 32'h003A_0000);
      ing.send(2'h2, 2'h0, 1'h0, 1'h0, 16'h0000);
      ing.send(2'h2, 2'h0, 1'h1, 1'h0, 16'h6004);
      ing.idle();
      wait_edit();
      chk(32'(edit_action), 32'h0000_0000);
      @(posedge hclk);
      chk(32'({edit_action, edit_tci}), 32'h0003_C00A);
      repeat (3) ing.drop(2'h1, 1'h0);
      repeat (2) ing.drop(2'h1, 1'h1);
      ing.drop(2'h3, 1'h1);
      ing.drop(2'h2, 1'h1);
      ing.idle();
      rdchk(8'h14, 32'h0000_0005);
      rdchk(8'h20, 32'h0000_0002);
      rdchk(8'h18, 32'h0000_0001);
      rdchk(8'h24, 32'h0000_0001);
      rdchk(8'h10, 32'h0000_0000);
      bus(1'h1, 8'h14, 32'hFFFF_FFFF);
      rdchk(8'h14, 32'h0000_0005);
      bus(1'h1, 8'h30, 32'hFFFF_FFFF);
      rdchk(8'h30, 32'h0000_0000);
      hresetn <= 1'h0;
      repeat (2) @(posedge hclk);
      chk(32'({edit_action, edit_tci}), 32'h0000_0000);
      chk(32'({hreadyout, hresp}), 32'h0000_0004);
      hresetn <= 1'h1;
      rdchk(8'h0C, 32'h0000_0001);
      conclude();
   end
endmodule
